// *** src/smtm_pkg.sv ***
// Purpose : shared constants and types for the signal measurement timer core
// Assumes : axi4-lite register access, 32-bit data, one aligned word per register
// Notes   : offsets are byte addresses

package smtm_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] SMTM_OFF_CTRL   = 8'h00;
	localparam logic [7:0] SMTM_OFF_PERIOD = 8'h04;
	localparam logic [7:0] SMTM_OFF_COUNT  = 8'h08;
	localparam logic [7:0] SMTM_OFF_STATUS = 8'h0c;
	localparam logic [7:0] SMTM_OFF_IRQST  = 8'h10;
	localparam logic [7:0] SMTM_OFF_IRQMSK = 8'h14;

	// ------------------------------------------------------------
	// control field positions
	// ------------------------------------------------------------
	localparam int SMTM_CTRL_RUN    = 0;
	localparam int SMTM_CTRL_REPEAT = 1;
	localparam int SMTM_CTRL_SIGNAL_POLARITY   = 2;
	localparam int SMTM_CTRL_WINDOW_POLARITY   = 3;
	localparam int SMTM_CTRL_CLOCK_POLARITY   = 4;
	localparam int SMTM_CTRL_WIDE   = 5;
	localparam int SMTM_CTRL_MODE   = 8;
	localparam int SMTM_MODE_W      = 4;

	localparam int SMTM_STAT_RUN    = 0;
	localparam int SMTM_IRQ_PMATCH  = 0;
	localparam int SMTM_IRQ_ACQ     = 1;
	localparam int SMTM_IRQ_W       = 2;

	localparam int SMTM_CNT_W       = 24;
	localparam logic [SMTM_CNT_W-1:0] SMTM_PERIOD_RST = 24'hffffff;
	localparam logic [SMTM_CNT_W-1:0] SMTM_NARROW_MSK = 24'h00ffff;

	localparam logic [1:0] SMTM_RESP_OKAY   = 2'b00;
	localparam logic [1:0] SMTM_RESP_SLVERR = 2'b10;

	typedef enum logic [3:0] {
		SMTM_MODE_TIMER      = 4'b0000,
		SMTM_MODE_GATED      = 4'b0001,
		SMTM_MODE_PERDUTY    = 4'b0010,
		SMTM_MODE_HILO       = 4'b0011,
		SMTM_MODE_WINDOWED   = 4'b0100,
		SMTM_MODE_GWINDOWED  = 4'b0101,
		SMTM_MODE_TOF        = 4'b0110,
		SMTM_MODE_CAPTURE    = 4'b0111,
		SMTM_MODE_COUNTER    = 4'b1000,
		SMTM_MODE_GCOUNTER   = 4'b1001,
		SMTM_MODE_WCOUNTER   = 4'b1010
	} smtm_mode_t;

	// synchronized input levels after polarity handling
	typedef struct packed {
		logic clk_lvl;
		logic win_lvl;
		logic sig_lvl;
	} smtm_inputs_t;

endpackage : smtm_pkg

// *** src/smtm_timer.sv ***
// Purpose : timer-mode core and mode select of a signal measurement timer
// Assumes : single 50 mhz aclk, synchronous active-low aresetn, axi4-lite slave
// Notes   : only timer mode counts; other legal modes are selected but idle here
//
// The register offsets and register access over AXI4-Lite were decided locally.

`timescale 1ns/1ps

module smtm_timer
	import smtm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        measure_clock,
	input  wire logic        window_input,
	input  wire logic        signal_input,
	output logic             irq
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0]           ctrl_q;
	logic [SMTM_CNT_W-1:0] period_limit_q;
	logic [SMTM_CNT_W-1:0] measure_counter_q;
	logic [SMTM_IRQ_W-1:0] irq_stat_q;
	logic [SMTM_IRQ_W-1:0] irq_mask_q;
	logic                  run_status_q;

	// ------------------------------------------------------------
	// input synchronizers
	// ------------------------------------------------------------
	// three stages; a change counts when stages two and three agree
	logic [2:0]   clk_sync_q;
	logic [2:0]   win_sync_q;
	logic [2:0]   sig_sync_q;
	smtm_inputs_t lvl_q;
	logic         mclk_prev_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_sync_q <= 3'h0;
			win_sync_q <= 3'h0;
			sig_sync_q <= 3'h0;
		end else begin
			clk_sync_q <= {clk_sync_q[1:0], measure_clock};
			win_sync_q <= {win_sync_q[1:0], window_input};
			sig_sync_q <= {sig_sync_q[1:0], signal_input};
		end
	end

	// window and signal levels are tracked but feed no logic in timer mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_q <= '0;
		end else begin
			if (clk_sync_q[1] == clk_sync_q[2])
				lvl_q.clk_lvl <= clk_sync_q[2] ^ ctrl_q[SMTM_CTRL_CLOCK_POLARITY];
			if (win_sync_q[1] == win_sync_q[2])
				lvl_q.win_lvl <= win_sync_q[2] ^ ctrl_q[SMTM_CTRL_WINDOW_POLARITY];
			if (sig_sync_q[1] == sig_sync_q[2])
				lvl_q.sig_lvl <= sig_sync_q[2] ^ ctrl_q[SMTM_CTRL_SIGNAL_POLARITY];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mclk_prev_q <= 1'b0;
		else
			mclk_prev_q <= lvl_q.clk_lvl;
	end

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	function automatic logic mode_is_legal(input logic [3:0] m);
		mode_is_legal = (m <= SMTM_MODE_WCOUNTER);
	endfunction : mode_is_legal

	logic [3:0] mode;
	logic       run_req;
	logic       mclk_edge;
	logic       tick;
	logic       legal;
	logic [SMTM_CNT_W-1:0] cnt_mask;
	logic [SMTM_CNT_W-1:0] per_eff;
	logic       match;

	assign mode      = ctrl_q[SMTM_CTRL_MODE +: SMTM_MODE_W];
	assign run_req   = ctrl_q[SMTM_CTRL_RUN];
	assign mclk_edge = lvl_q.clk_lvl & ~mclk_prev_q;
	assign legal     = mode_is_legal(mode);
	// only timer mode advances; gated, measure and counter modes are selected but idle
	assign tick      = mclk_edge & run_status_q & legal
	                   & (mode == SMTM_MODE_TIMER);
	assign cnt_mask  = ctrl_q[SMTM_CTRL_WIDE] ? SMTM_PERIOD_RST : SMTM_NARROW_MSK;
	assign per_eff   = period_limit_q & cnt_mask;
	assign match     = tick & (measure_counter_q == per_eff);

	// ------------------------------------------------------------
	// run status and counter
	// ------------------------------------------------------------
	// run status follows the request one cycle later in legal modes only, standing in for the sync lag
	always_ff @(posedge aclk) begin
		if (!aresetn)
			run_status_q <= 1'b0;
		else
			run_status_q <= run_req & legal;
	end

	// no acquisition registers exist; timer mode only counts
	always_ff @(posedge aclk) begin
		if (!aresetn)
			measure_counter_q <= '0;
		else if (match)
			measure_counter_q <= '0;
		else if (tick)
			measure_counter_q <= (measure_counter_q + 24'h000001) & cnt_mask;
	end

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	logic       aw_held_q;
	logic       w_held_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_go;
	logic        wr_hit;

	assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0;
			w_strb_q      <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_q <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (aw_addr_q)
			SMTM_OFF_CTRL, SMTM_OFF_PERIOD, SMTM_OFF_IRQST, SMTM_OFF_IRQMSK: wr_hit = 1'b1;
			SMTM_OFF_COUNT, SMTM_OFF_STATUS:                                 wr_hit = 1'b1;
			default:                                                         wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= SMTM_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? SMTM_RESP_OKAY : SMTM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			apply_strb[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
	endfunction : apply_strb

	logic wr_ctrl;
	logic [31:0] ctrl_wr;
	assign wr_ctrl = wr_go & (aw_addr_q == SMTM_OFF_CTRL);
	assign ctrl_wr = apply_strb(ctrl_q, w_data_q, w_strb_q);

	logic [31:0] period_wr;
	assign period_wr = apply_strb({8'h00, period_limit_q}, w_data_q, w_strb_q);

	// run_request is written only by software; window and signal never reach it.
	// single-shot stop after acquisition never fires because timer mode never acquires
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_q <= 32'h0;
		else if (wr_ctrl)
			ctrl_q <= ctrl_wr & 32'h00000f3f;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			period_limit_q <= SMTM_PERIOD_RST;
		else if (wr_go & (aw_addr_q == SMTM_OFF_PERIOD))
			period_limit_q <= period_wr[SMTM_CNT_W-1:0];
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	logic [SMTM_IRQ_W-1:0] irq_set;
	logic [SMTM_IRQ_W-1:0] irq_clr;
	assign irq_set = {1'b0, match};
	assign irq_clr = (wr_go & (aw_addr_q == SMTM_OFF_IRQST) & w_strb_q[0])
	                 ? w_data_q[SMTM_IRQ_W-1:0] : '0;

	logic [SMTM_IRQ_W-1:0] irq_stat_d;
	logic [SMTM_IRQ_W-1:0] irq_mask_d;
	// a new event wins over a clear in the same cycle
	assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
	assign irq_mask_d = (wr_go & (aw_addr_q == SMTM_OFF_IRQMSK) & w_strb_q[0])
	                    ? w_data_q[SMTM_IRQ_W-1:0] : irq_mask_q;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_stat_q <= '0;
		else
			irq_stat_q <= irq_stat_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_mask_q <= '0;
		else
			irq_mask_q <= irq_mask_d;
	end

	// built from next state so the pin tracks status and mask in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_d & irq_mask_d);
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	logic [31:0] rd_mux;
	logic        rd_hit;

	always_comb begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			SMTM_OFF_CTRL:   rd_mux = ctrl_q;
			SMTM_OFF_PERIOD: rd_mux = {8'h00, period_limit_q};
			SMTM_OFF_COUNT:  rd_mux = {8'h00, measure_counter_q};
			SMTM_OFF_STATUS: rd_mux = {31'h0, run_status_q};
			SMTM_OFF_IRQST:  rd_mux = {30'h0, irq_stat_q};
			SMTM_OFF_IRQMSK: rd_mux = {30'h0, irq_mask_q};
			default:         rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= SMTM_RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_hit ? SMTM_RESP_OKAY : SMTM_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_hold_when_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
		!run_status_q |=> $stable(measure_counter_q))
		else $error("counter moved while stopped");

	a_match_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		match |=> measure_counter_q == '0)
		else $error("counter not cleared on period match");

	a_match_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		match |=> irq_stat_q[SMTM_IRQ_PMATCH])
		else $error("period match flag not set");

	a_reserved_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode > SMTM_MODE_WCOUNTER) |-> !tick && !match)
		else $error("reserved mode counted");

	// a stopped counter may keep wide bits after a width change until its next step
	a_narrow_width: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_q[SMTM_CTRL_WIDE] && tick |=> measure_counter_q[SMTM_CNT_W-1:16] == 8'h00)
		else $error("16-bit counter overran");

	a_run_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(run_req) && legal ##1 run_req |-> run_status_q)
		else $error("run status did not follow request");

	a_run_sw_only: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_ctrl |=> $stable(run_req))
		else $error("run request changed without a write");

	a_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && !match |=> measure_counter_q ==
			(($past(measure_counter_q) + 24'h000001) & $past(cnt_mask)))
		else $error("counter step wrong");

	a_edge_only: assert property (@(posedge aclk) disable iff (!aresetn)
		!mclk_edge |=> $stable(measure_counter_q))
		else $error("counter moved without clock edge");

	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == (|(irq_stat_q & irq_mask_q)))
		else $error("interrupt level does not follow unmasked flags");

endmodule : smtm_timer

// *** tb/tb_top.sv ***
// Purpose : self-checking bench for the timer-mode core
// Assumes : 50 mhz aclk, bench acts as axi4-lite master, measure clock pulses of 16 aclk
// Notes   : a reference model of counter and irq status predicts the count and irq status readbacks

`timescale 1ns/1ps

module tb_top;
	import smtm_pkg::*;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        measure_clock = 1'b0, window_input = 1'b0, signal_input = 1'b0;
	logic        irq;
	int          num_errors = 0, n_checks = 0, cyc = 0;
	int          m_cnt = 0, m_per = 0, m_msk = 0, m_run = 0, m_mode = 0, m_st = 0;
	int          p;
	logic [31:0] d;
	logic [1:0]  r;

	smtm_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .measure_clock(measure_clock),
		.window_input(window_input), .signal_input(signal_input), .irq(irq));

	always #10 aclk = ~aclk;

	// noise on window and signal inputs all run long; timer mode must ignore it
	always @(posedge aclk) begin
		window_input <= 1'($urandom);
		signal_input <= 1'($urandom);
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected data at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_data

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected resp at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_resp

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// bus tasks, entered just after a rising edge
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] rs;
		axi_wr(a, v, rs);
		chk_resp(rs, SMTM_RESP_OKAY);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rs;
		axi_rd(a, v, rs);
		chk_data(v, e);
		chk_resp(rs, SMTM_RESP_OKAY);
	endtask : rd_chk

	// ------------------------------------------------------------
	// model
	// ------------------------------------------------------------
	task automatic set_ctrl(input int run, input int mode, input int clock_polarity, input int wide);
		m_run = run;
		m_mode = mode;
		m_msk = wide ? 'hffffff : 'hffff;
		wr(SMTM_OFF_CTRL, {20'h0, 4'(mode), 2'b00, 1'(wide), 1'(clock_polarity), 3'b000, 1'(run)});
	endtask : set_ctrl

	// one full pulse gives exactly one rising edge of the polarity-corrected level
	task automatic ticks(input int n);
		repeat (n) begin
			measure_clock <= ~measure_clock;
			repeat (8) @(posedge aclk);
			measure_clock <= ~measure_clock;
			repeat (8) @(posedge aclk);
			if (m_run == 1 && m_mode == 0) begin
				if (m_cnt == (m_per & m_msk)) begin
					m_cnt = 0;
					m_st = m_st | 1;
				end else
					m_cnt = (m_cnt + 1) & m_msk;
			end
		end
	endtask : ticks

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(25511));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		m_per = 'hffffff;
		rd_chk(SMTM_OFF_CTRL, 32'h0);
		rd_chk(SMTM_OFF_PERIOD, 32'hffffff);
		rd_chk(SMTM_OFF_COUNT, 32'h0);
		rd_chk(SMTM_OFF_STATUS, 32'h0);
		rd_chk(SMTM_OFF_IRQST, 32'h0);
		axi_rd(8'h18, d, r);
		chk_resp(r, SMTM_RESP_SLVERR);
		chk_data(d, 32'h0);
		// short period, wraps twice, irq unmasked
		p = 2 + $urandom % 5;
		m_per = p;
		wr(SMTM_OFF_PERIOD, 32'(p));
		wr(SMTM_OFF_IRQMSK, 32'h1);
		set_ctrl(1, 0, 0, 1);
		ticks(2 * p + 3);
		rd_chk(SMTM_OFF_COUNT, 32'(m_cnt));
		rd_chk(SMTM_OFF_STATUS, 32'h1);
		rd_chk(SMTM_OFF_IRQST, 32'(m_st));
		chk_data({31'h0, irq}, 32'h1);
		wr(SMTM_OFF_IRQMSK, 32'h0);
		repeat (3) @(posedge aclk);
		chk_data({31'h0, irq}, 32'h0);
		wr(SMTM_OFF_IRQST, 32'h1);
		m_st = 0;
		rd_chk(SMTM_OFF_IRQST, 32'h0);
		wr(SMTM_OFF_IRQMSK, 32'h1);
		// stopped timer holds its value
		set_ctrl(0, 0, 0, 1);
		ticks(3);
		rd_chk(SMTM_OFF_COUNT, 32'(m_cnt));
		rd_chk(SMTM_OFF_STATUS, 32'h0);
		// narrow counter compares the period at 16 bits
		m_per = 'h010007;
		wr(SMTM_OFF_PERIOD, 32'h010007);
		set_ctrl(1, 0, 0, 0);
		ticks(10);
		rd_chk(SMTM_OFF_COUNT, 32'(m_cnt));
		rd_chk(SMTM_OFF_IRQST, 32'(m_st));
		chk_data({31'h0, irq}, 32'(m_st));
		// inverted measure clock, changed while stopped so its edge is not counted
		set_ctrl(0, 0, 1, 1);
		repeat (10) @(posedge aclk);
		set_ctrl(1, 0, 1, 1);
		ticks(3);
		rd_chk(SMTM_OFF_COUNT, 32'(m_cnt));
		set_ctrl(0, 0, 0, 1);
		repeat (10) @(posedge aclk);
		wr(SMTM_OFF_IRQST, 32'h3);
		m_st = 0;
		// every other mode code leaves the counter alone
		for (int m = 1; m < 16; m++) begin
			set_ctrl(1, m, 0, 1);
			ticks(2);
			rd_chk(SMTM_OFF_COUNT, 32'(m_cnt));
			rd_chk(SMTM_OFF_STATUS, 32'(m <= 10));
			rd_chk(SMTM_OFF_IRQST, 32'h0);
			rd_chk(SMTM_OFF_CTRL, {20'h0, 4'(m), 8'h21});
		end
		final_report();
	end

endmodule : tb_top
